//--- hdl/conv_protect_fsm.sv
// protect sequence of one switching converter: masked detect, warn, retry
// assumes fault inputs already synchronised to clk_sys
`timescale 1ns/10ps
module conv_protect_fsm
    import conv_protect_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // fault levels
    input wire logic ocFault,
    input wire logic uvFault,
    input wire logic extFault,
    // selected times in cycles
    input wire count_t ocMaskCyc,
    input wire count_t uvMaskCyc,
    input wire count_t retryCyc,
    // status
    output logic warn,
    output logic inProtect
);
    prot_state_t state_r; // sequence state
    count_t ocCnt_r; // over-current persistence
    count_t uvCnt_r; // under-voltage persistence
    count_t retryCnt_r; // time spent in protect
    logic ocTrip; // over-current outlived its mask
    logic uvTrip; // under-voltage outlived its mask
    logic retryDone; // interval over

    assign ocTrip = ocFault && (ocCnt_r >= ocMaskCyc - count_t'(1));
    assign uvTrip = uvFault && (uvCnt_r >= uvMaskCyc - count_t'(1));
    assign retryDone = (retryCnt_r >= retryCyc - count_t'(1));
    assign warn = (state_r == ST_WARN);
    assign inProtect = (state_r == ST_PROTECT);

    // mask timers restart whenever the fault drops out
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ocCnt_r <= '0;
            uvCnt_r <= '0;
        end
        else
        begin
            ocCnt_r <= (ocFault && state_r == ST_NORMAL && !ocTrip) ? ocCnt_r + count_t'(1)
                : '0; // RULE19
            uvCnt_r <= (uvFault && state_r == ST_NORMAL && !uvTrip) ? uvCnt_r + count_t'(1)
                : '0; // RULE19
        end
    end

    // interval counter, only runs while in protect
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            retryCnt_r <= '0;
        else if (state_r != ST_PROTECT || retryDone)
            retryCnt_r <= '0;
        else
            retryCnt_r <= retryCnt_r + count_t'(1); // RULE6
    end

    // state sequence
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            state_r <= ST_NORMAL;
        else
        begin
            case (state_r)
                ST_NORMAL:
                    if (ocTrip || uvTrip || extFault)
                        state_r <= ST_WARN; // RULE3 RULE11
                ST_WARN:
                    state_r <= ST_PROTECT;
                ST_PROTECT:
                    // restart attempt; a lasting outside fault keeps protect
                    if (retryDone && !extFault)
                        state_r <= ST_NORMAL; // RULE5 RULE7
                default:
                    state_r <= ST_NORMAL;
            endcase
        end
    end

    a_warn_before_prot: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(state_r == ST_PROTECT) |-> $past(state_r) == ST_WARN) // RULE9
        else $error("protect entered without warn");
    a_retry_leaves: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_r == ST_PROTECT && retryDone && !extFault |=> state_r == ST_NORMAL) // RULE7
        else $error("restart attempt missed");
endmodule : conv_protect_fsm

//--- hdl/conv_protect_map.svh
// register map, field positions, reset values and times of the protect block
// assumes a 40 MHz system clock; times are in ns
`ifndef CONV_PROTECT_MAP_SVH
`define CONV_PROTECT_MAP_SVH
`define ADDR_AUX_RAIL 8'h1A
`define ADDR_PROT_TIMING 8'h1B
`define AUX_RAIL_RST 8'h00
`define PROT_TIMING_RST 8'h44
`define AUX1_BIT 0
`define AUX2_BIT 1
`define RETRY_CORE_HI 7
`define RETRY_CORE_LO 6
`define OCM_CORE_HI 5
`define OCM_CORE_LO 4
`define RETRY_INTER_HI 3
`define RETRY_INTER_LO 2
`define OCM_INTER_HI 1
`define OCM_INTER_LO 0
`define FLAG_INTER_VOLT 0
`define FLAG_CORE_VOLT 1
`define FLAG_INTER_PROT 2
`define FLAG_CORE_PROT 3
`define FLAG_W 4
`define CNT_W 24
`define CLK_PERIOD_NS 25
`define UV_MASK_NS 92000
`define OC_MASK0_NS 122000
`define OC_MASK1_NS 610000
`define OC_MASK2_NS 1098000
`define RETRY0_NS 15600000
`define RETRY1_NS 31200000
`define RETRY2_NS 124900000
`define RETRY3_NS 249900000
`define RST_DELAY_NS 12000000
`endif

//--- hdl/conv_protect_pkg.sv
// types shared by the converter protect logic
// assumes the map header sits beside it
`include "conv_protect_map.svh"
package conv_protect_pkg;
    // protect sequence of one converter
    typedef enum logic [1:0] {ST_NORMAL, ST_WARN, ST_PROTECT} prot_state_t;
    // long timing counts
    typedef logic [`CNT_W-1:0] count_t;
endpackage : conv_protect_pkg

//--- hdl/converter_protect_and_aux_rail_ctrl.sv
// protect control of two converters, aux rail enables, core undervoltage reset
// assumes fault inputs from analog detectors (asynchronous), register port
// from the serial interface decoder on clk_sys
`timescale 1ns/10ps
// What this block does
// (RULE1) register 1AH enables aux rails, default off
// (RULE2) intermediate or masked core overvoltage stops both converters switching
// (RULE3) masked intermediate fault enters interval operation
// (RULE4) programmable current mask, fixed 92us others
// (RULE5) protect mode retries intermediate converter periodically
// (RULE6) retry period comes from software setting
// (RULE7) fault gone at retry returns normal
// (RULE8) core or analog overvoltage protects intermediate
// (RULE9) interrupt low before intermediate protect
// (RULE10) interrupt low before core protect
// (RULE11) masked core fault enters interval operation
// (RULE12) voltage fault sets flag and interrupt
// (RULE13) enable bit adds core undervoltage reset
// (RULE14) reset low at once, held during undervoltage
// (RULE15) reset released 12ms after recovery
// (RULE16) register 1BH selects retry intervals
// (RULE17) register 1BH selects overcurrent masks
// (RULE18) timing register survives reset output
// (RULE19) mask timer restarts when fault clears
module converter_protect_and_aux_rail_ctrl
    import conv_protect_pkg::*;
#(
    parameter int unsigned TICK_NS = `CLK_PERIOD_NS, // ns per count of every timer
    parameter int unsigned UV_MASK_CYC = (`UV_MASK_NS + TICK_NS - 1) / TICK_NS,
    parameter int unsigned OC_MASK0_CYC = (`OC_MASK0_NS + TICK_NS - 1) / TICK_NS,
    parameter int unsigned OC_MASK1_CYC = (`OC_MASK1_NS + TICK_NS - 1) / TICK_NS,
    parameter int unsigned OC_MASK2_CYC = (`OC_MASK2_NS + TICK_NS - 1) / TICK_NS,
    parameter int unsigned RETRY0_CYC = (`RETRY0_NS + TICK_NS - 1) / TICK_NS,
    parameter int unsigned RETRY1_CYC = (`RETRY1_NS + TICK_NS - 1) / TICK_NS,
    parameter int unsigned RETRY2_CYC = (`RETRY2_NS + TICK_NS - 1) / TICK_NS,
    parameter int unsigned RETRY3_CYC = (`RETRY3_NS + TICK_NS - 1) / TICK_NS,
    parameter int unsigned RST_DELAY_CYC = (`RST_DELAY_NS + TICK_NS - 1) / TICK_NS
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // analog detector levels, asynchronous
    input wire logic interOv,
    input wire logic interOc,
    input wire logic interUv,
    input wire logic coreOv,
    input wire logic coreOc,
    input wire logic coreUv,
    input wire logic analogOv,
    // configuration and flag clear
    input wire logic core_uv_reset_enable,
    input wire logic [`FLAG_W-1:0] flagClear,
    // converter control
    output logic interSwitchEn,
    output logic coreSwitchEn,
    output logic interProtect,
    output logic coreProtect,
    // aux rails
    output logic aux_rail1_enable,
    output logic aux_rail2_enable,
    // status, interrupt, reset
    output logic [`FLAG_W-1:0] statusFlags,
    output logic irq_out_n,
    output logic reset_out_n
);
    localparam int unsigned MIN_CYC = 2;
    localparam int unsigned MAX_CYC = (1 << `CNT_W) - 1;

    // refuse counts the counters cannot hold
    if (TICK_NS == 0 || UV_MASK_CYC < MIN_CYC || OC_MASK0_CYC < MIN_CYC || RETRY0_CYC < MIN_CYC
        || RST_DELAY_CYC < MIN_CYC || RETRY3_CYC > MAX_CYC || OC_MASK2_CYC > MAX_CYC
        || RST_DELAY_CYC > MAX_CYC)
    begin : g_bad_count
        $error("timing count out of range");
    end

    logic [7:0] auxRail_r; // aux rail control register
    logic [7:0] protTiming_r; // protect timing register
    logic [6:0] faultMeta_r; // first sync stage
    logic [6:0] faultSync_r; // second sync stage
    logic interOvS, interOcS, interUvS, coreOvS, coreOcS, coreUvS, analogOvS;
    count_t coreOvCnt_r; // core overvoltage mask timer
    logic coreOvHit; // core overvoltage outlived its mask
    logic ovStop; // stop both converters
    logic interWarn, interInProt, coreWarn, coreInProt;
    logic [`FLAG_W-1:0] flags_r; // sticky status
    logic [`FLAG_W-1:0] flags_nxt;
    logic [`FLAG_W-1:0] flagSet;
    logic coreUvRst; // reset condition active
    count_t rstCnt_r; // release delay

    // overcurrent mask select decode
    function automatic count_t ocMaskSel(input logic [1:0] sel);
        case (sel)
            2'h2: return count_t'(OC_MASK1_CYC);
            2'h3: return count_t'(OC_MASK2_CYC);
            default: return count_t'(OC_MASK0_CYC);
        endcase
    endfunction : ocMaskSel

    // retry interval select decode
    function automatic count_t retrySel(input logic [1:0] sel);
        case (sel)
            2'h0: return count_t'(RETRY0_CYC);
            2'h2: return count_t'(RETRY2_CYC);
            2'h3: return count_t'(RETRY3_CYC);
            default: return count_t'(RETRY1_CYC);
        endcase
    endfunction : retrySel

    // register writes; only resetn clears, never the reset output
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            auxRail_r <= `AUX_RAIL_RST; // RULE1
            protTiming_r <= `PROT_TIMING_RST; // RULE18
        end
        else if (regWrEn)
        begin
            if (regAddr == `ADDR_AUX_RAIL)
                auxRail_r <= regWrData; // RULE1
            else if (regAddr == `ADDR_PROT_TIMING)
                protTiming_r <= regWrData; // RULE16 RULE17
        end
    end

    // register reads, unmapped reads zero
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            regRdData <= 8'h00;
            regRdValid <= 1'b0;
        end
        else
        begin
            regRdValid <= regRdEn;
            if (!regRdEn)
                regRdData <= 8'h00;
            else if (regAddr == `ADDR_AUX_RAIL)
                regRdData <= {6'h00, auxRail_r[`AUX2_BIT], auxRail_r[`AUX1_BIT]};
            else if (regAddr == `ADDR_PROT_TIMING)
                regRdData <= protTiming_r;
            else
                regRdData <= 8'h00;
        end
    end

    // two-stage sync of detector levels
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            faultMeta_r <= '0;
            faultSync_r <= '0;
        end
        else
        begin
            faultMeta_r <= {interOv, interOc, interUv, coreOv, coreOc, coreUv, analogOv};
            faultSync_r <= faultMeta_r;
        end
    end
    assign {interOvS, interOcS, interUvS, coreOvS, coreOcS, coreUvS, analogOvS} = faultSync_r;

    // fixed mask on core overvoltage
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            coreOvCnt_r <= '0;
        else if (!coreOvS)
            coreOvCnt_r <= '0; // RULE19
        else if (!coreOvHit)
            coreOvCnt_r <= coreOvCnt_r + count_t'(1); // RULE4
    end
    assign coreOvHit = coreOvS && (coreOvCnt_r >= count_t'(UV_MASK_CYC) - count_t'(1));
    assign ovStop = interOvS || coreOvHit; // RULE2

    // intermediate converter sequence
    conv_protect_fsm u_inter
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ocFault(interOcS),
        .uvFault(interUvS),
        .extFault(coreOvHit || analogOvS), // RULE8
        .ocMaskCyc(ocMaskSel(protTiming_r[`OCM_INTER_HI:`OCM_INTER_LO])), // RULE4 RULE17
        .uvMaskCyc(count_t'(UV_MASK_CYC)), // RULE4
        .retryCyc(retrySel(protTiming_r[`RETRY_INTER_HI:`RETRY_INTER_LO])), // RULE6
        .warn(interWarn),
        .inProtect(interInProt)
    );

    // core converter sequence
    conv_protect_fsm u_core
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ocFault(coreOcS),
        .uvFault(coreUvS),
        .extFault(1'b0),
        .ocMaskCyc(ocMaskSel(protTiming_r[`OCM_CORE_HI:`OCM_CORE_LO])), // RULE17
        .uvMaskCyc(count_t'(UV_MASK_CYC)),
        .retryCyc(retrySel(protTiming_r[`RETRY_CORE_HI:`RETRY_CORE_LO])), // RULE16
        .warn(coreWarn),
        .inProtect(coreInProt)
    );

    // converter control and aux outputs
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            interSwitchEn <= 1'b0;
            coreSwitchEn <= 1'b0;
            interProtect <= 1'b0;
            coreProtect <= 1'b0;
            aux_rail1_enable <= 1'b0;
            aux_rail2_enable <= 1'b0;
        end
        else
        begin
            interSwitchEn <= !ovStop && !interInProt; // RULE2 RULE3
            coreSwitchEn <= !ovStop && !coreInProt; // RULE2 RULE11
            interProtect <= interInProt;
            coreProtect <= coreInProt;
            aux_rail1_enable <= auxRail_r[`AUX1_BIT]; // RULE1
            aux_rail2_enable <= auxRail_r[`AUX2_BIT]; // RULE1
        end
    end

    // sticky flags, a set beats a clear in the same cycle
    always_comb
    begin
        flagSet = '0;
        flagSet[`FLAG_INTER_VOLT] = interOvS || interUvS; // RULE12
        flagSet[`FLAG_CORE_VOLT] = coreOvS || coreUvS; // RULE12
        flagSet[`FLAG_INTER_PROT] = interWarn; // RULE9
        flagSet[`FLAG_CORE_PROT] = coreWarn; // RULE10
        flags_nxt = (flags_r & ~flagClear) | flagSet;
    end

    // flag storage and interrupt
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            flags_r <= '0;
            statusFlags <= '0;
            irq_out_n <= 1'b1;
        end
        else
        begin
            flags_r <= flags_nxt;
            statusFlags <= flags_nxt;
            irq_out_n <= ~|flags_nxt; // RULE9 RULE10 RULE12
        end
    end

    // core undervoltage reset with release delay
    assign coreUvRst = core_uv_reset_enable && coreUvS; // RULE13
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            reset_out_n <= 1'b1;
            rstCnt_r <= '0;
        end
        else if (coreUvRst)
        begin
            reset_out_n <= 1'b0; // RULE14
            rstCnt_r <= '0;
        end
        else if (!reset_out_n)
        begin
            if (rstCnt_r >= count_t'(RST_DELAY_CYC) - count_t'(1))
                reset_out_n <= 1'b1; // RULE15
            else
                rstCnt_r <= rstCnt_r + count_t'(1);
        end
    end

    a_ov_stop: assert property (@(posedge clk_sys) disable iff (!resetn)
        ovStop |=> !interSwitchEn && !coreSwitchEn) // RULE2
        else $error("switching not stopped on overvoltage");
    a_irq_lead_inter: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(interProtect) |-> $past(!irq_out_n)) // RULE9
        else $error("interrupt late for intermediate protect");
    a_irq_lead_core: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(coreProtect) |-> $past(!irq_out_n)) // RULE10
        else $error("interrupt late for core protect");
    a_flag_volt: assert property (@(posedge clk_sys) disable iff (!resetn)
        (coreOvS || coreUvS) |=> statusFlags[`FLAG_CORE_VOLT] && !irq_out_n) // RULE12
        else $error("core voltage flag missing");
    a_rst_assert: assert property (@(posedge clk_sys) disable iff (!resetn)
        coreUvRst |=> !reset_out_n && rstCnt_r == '0) // RULE14
        else $error("reset not asserted on undervoltage");
    a_rst_release: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(reset_out_n) |-> $past(rstCnt_r) == count_t'(RST_DELAY_CYC) - count_t'(1)) // RULE15
        else $error("reset released early");
    a_uv_no_rst: assert property (@(posedge clk_sys) disable iff (!resetn)
        coreUvS && !core_uv_reset_enable && reset_out_n |=> reset_out_n) // RULE13
        else $error("reset without enable");
    a_aux_write: assert property (@(posedge clk_sys) disable iff (!resetn)
        regWrEn && regAddr == `ADDR_AUX_RAIL
        |=> ##2 aux_rail2_enable == $past(regWrData[`AUX2_BIT], 3)) // RULE1
        else $error("aux rail enable not following write");
    a_core_ov_mask: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(coreOvS) |-> !coreOvHit [*7]) // RULE4
        else $error("core overvoltage unmasked");
endmodule : converter_protect_and_aux_rail_ctrl

//--- testbench/converter_protect_and_aux_rail_ctrl_tb.sv
// bench of the converter protect block with shortened mask and retry counts
// assumes the mcu model drives the register port
`timescale 1ns/10ps
`include "conv_protect_map.svh"
module converter_protect_and_aux_rail_ctrl_tb;
    // stimulus, all idle at time zero
    logic clk_sys = 1'b0, resetn = 1'b0, core_uv_reset_enable = 1'b0;
    logic interOv = 1'b0, interOc = 1'b0, interUv = 1'b0, analogOv = 1'b0;
    logic coreOv = 1'b0, coreOc = 1'b0, coreUv = 1'b0;
    logic [3:0] flagClear = 4'h0;
    // register port and outputs
    logic [7:0] regAddr, regWrData, regRdData;
    logic regWrEn, regRdEn, regRdValid, interSwitchEn, coreSwitchEn, interProtect;
    logic coreProtect, aux_rail1_enable, aux_rail2_enable, irq_out_n, reset_out_n;
    logic [3:0] statusFlags;
    // score keeping
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;

    converter_protect_and_aux_rail_ctrl #(.TICK_NS(12000), .RETRY0_CYC(40), .RETRY1_CYC(50),
        .RETRY2_CYC(60), .RETRY3_CYC(70)) u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid), .interOv(interOv), .interOc(interOc), .interUv(interUv),
        .coreOv(coreOv), .coreOc(coreOc), .coreUv(coreUv), .analogOv(analogOv),
        .core_uv_reset_enable(core_uv_reset_enable), .flagClear(flagClear),
        .interSwitchEn(interSwitchEn), .coreSwitchEn(coreSwitchEn),
        .interProtect(interProtect), .coreProtect(coreProtect),
        .aux_rail1_enable(aux_rail1_enable), .aux_rail2_enable(aux_rail2_enable),
        .statusFlags(statusFlags), .irq_out_n(irq_out_n), .reset_out_n(reset_out_n)
    );

    mcu_model u_mcu (
        .clk_sys(clk_sys), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid)
    );

    // 40 MHz clock
    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    // hang guard
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    // single bit result
    task automatic check_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    // register byte result
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte

    // measured cycle count within a window
    task automatic check_range(input string what, input int lo, input int hi, input int got);
        checks++;
        if (got < lo || got > hi)
        begin
            bad_count++;
            $display("unexpected %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : check_range

    // counts cycles while a protect output keeps a level; notes an early interrupt
    task automatic count_while(input logic core, input logic lvl, output int n,
                               output logic irqLow);
        n = 0;
        irqLow = 1'b0;
        while (((core ? coreProtect : interProtect) === lvl) && n < 300)
        begin
            irqLow = (irq_out_n === 1'b0);
            @(negedge clk_sys);
            n++;
        end
    endtask : count_while

    // pulse every flag clear, interrupt must go away
    task automatic clear_flags();
        @(posedge clk_sys);
        flagClear <= 4'hF;
        @(posedge clk_sys);
        flagClear <= 4'h0;
        repeat (3) @(negedge clk_sys);
        check_bit("interrupt released", 1'b1, irq_out_n);
    endtask : clear_flags

    // reset values, masked read bits, aux rail enables, unmapped read
    task automatic test_registers();
        logic [7:0] d;
        logic v;
        u_mcu.read_reg(`ADDR_AUX_RAIL, d, v);
        check_byte("aux rail reset", 8'h00, d);
        check_bit("read answer", 1'b1, v);
        u_mcu.read_reg(`ADDR_PROT_TIMING, d, v);
        check_byte("timing reset", 8'h44, d);
        u_mcu.read_reg(8'h55, d, v);
        check_byte("unmapped read", 8'h00, d);
        u_mcu.write_reg(`ADDR_AUX_RAIL, 8'hFE);
        u_mcu.read_reg(`ADDR_AUX_RAIL, d, v);
        check_byte("aux rail readback", 8'h02, d);
        check_bit("aux rail one", 1'b0, aux_rail1_enable);
        check_bit("aux rail two", 1'b1, aux_rail2_enable);
        u_mcu.write_reg(`ADDR_AUX_RAIL, 8'h01);
        repeat (3) @(negedge clk_sys);
        check_bit("aux rail one on", 1'b1, aux_rail1_enable);
        check_bit("aux rail two off", 1'b0, aux_rail2_enable);
        $display("test registers done");
    endtask : test_registers

    // every mask and retry code, glitch filter, fixed undervoltage mask
    task automatic test_inter_protect();
        int n;
        logic irqLow;
        int maskCyc[4] = '{11, 11, 51, 92};
        for (int i = 0; i < 4; i++)
        begin
            u_mcu.write_reg(`ADDR_PROT_TIMING, {4'h4, i[1:0], i[1:0]});
            @(posedge clk_sys);
            interOc <= 1'b1;
            count_while(1'b0, 1'b0, n, irqLow);
            check_range("oc mask cycles", maskCyc[i], maskCyc[i] + 8, n);
            check_bit("warn before protect", 1'b1, irqLow);
            check_bit("inter switch stopped", 1'b0, interSwitchEn);
            @(posedge clk_sys);
            interOc <= 1'b0;
            count_while(1'b0, 1'b1, n, irqLow);
            check_range("retry cycles", 36 + 10 * i, 42 + 10 * i, n);
            @(negedge clk_sys);
            check_bit("inter switch resumed", 1'b1, interSwitchEn);
            clear_flags();
        end
        repeat (2)
        begin
            @(posedge clk_sys);
            interOc <= 1'b1;
            repeat (60) @(posedge clk_sys);
            interOc <= 1'b0;
        end
        repeat (5) @(negedge clk_sys);
        check_bit("glitch ignored", 1'b0, statusFlags[`FLAG_INTER_PROT]);
        @(posedge clk_sys);
        interUv <= 1'b1;
        count_while(1'b0, 1'b0, n, irqLow);
        check_range("uv mask cycles", 8, 16, n);
        check_bit("inter volt flag", 1'b1, statusFlags[`FLAG_INTER_VOLT]);
        @(posedge clk_sys);
        interUv <= 1'b0;
        count_while(1'b0, 1'b1, n, irqLow);
        clear_flags();
        $display("test inter protect done");
    endtask : test_inter_protect

    // core undervoltage reset, release delay, timing register kept
    task automatic test_core_reset();
        int n;
        logic irqLow;
        logic [7:0] d;
        logic v;
        u_mcu.write_reg(`ADDR_PROT_TIMING, 8'hA5);
        @(posedge clk_sys);
        core_uv_reset_enable <= 1'b1;
        coreUv <= 1'b1;
        repeat (4) @(negedge clk_sys);
        check_bit("reset at once", 1'b0, reset_out_n);
        count_while(1'b1, 1'b0, n, irqLow);
        check_range("core uv mask", 4, 12, n);
        check_bit("warn before core protect", 1'b1, irqLow);
        check_bit("reset held", 1'b0, reset_out_n);
        check_bit("core volt flag", 1'b1, statusFlags[`FLAG_CORE_VOLT]);
        check_bit("core prot flag", 1'b1, statusFlags[`FLAG_CORE_PROT]);
        @(posedge clk_sys);
        coreUv <= 1'b0;
        n = 0;
        while (reset_out_n !== 1'b1 && n < 1100)
        begin
            @(negedge clk_sys);
            n++;
        end
        check_range("reset release delay", 999, 1006, n);
        u_mcu.read_reg(`ADDR_PROT_TIMING, d, v);
        check_byte("timing kept", 8'hA5, d);
        @(posedge clk_sys);
        core_uv_reset_enable <= 1'b0;
        coreUv <= 1'b1;
        repeat (20) @(negedge clk_sys);
        check_bit("no reset when off", 1'b1, reset_out_n);
        @(posedge clk_sys);
        coreUv <= 1'b0;
        repeat (80) @(negedge clk_sys);
        clear_flags();
        $display("test core reset done");
    endtask : test_core_reset

    // overvoltage on each source
    task automatic test_over_voltage();
        int n;
        logic irqLow;
        @(posedge clk_sys);
        interOv <= 1'b1;
        repeat (5) @(negedge clk_sys);
        check_bit("inter switch on ov", 1'b0, interSwitchEn);
        check_bit("core switch on ov", 1'b0, coreSwitchEn);
        check_bit("ov flag", 1'b1, statusFlags[`FLAG_INTER_VOLT]);
        @(posedge clk_sys);
        interOv <= 1'b0;
        coreOv <= 1'b1;
        count_while(1'b0, 1'b0, n, irqLow);
        check_range("core ov mask", 8, 16, n);
        check_bit("core switch on core ov", 1'b0, coreSwitchEn);
        check_bit("warn before ov protect", 1'b1, irqLow);
        @(posedge clk_sys);
        coreOv <= 1'b0;
        analogOv <= 1'b1;
        repeat (100) @(negedge clk_sys);
        check_bit("analog ov protect", 1'b1, interProtect);
        @(posedge clk_sys);
        analogOv <= 1'b0;
        repeat (80) @(negedge clk_sys);
        check_bit("protect left", 1'b0, interProtect);
        clear_flags();
        $display("test over voltage done");
    endtask : test_over_voltage

    // verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    // main sequence
    initial
    begin
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(negedge clk_sys);
        check_bit("reset output idle", 1'b1, reset_out_n);
        check_bit("interrupt idle", 1'b1, irq_out_n);
        check_bit("inter switch after reset", 1'b1, interSwitchEn);
        test_registers();
        test_inter_protect();
        test_core_reset();
        test_over_voltage();
        tally_and_finish();
    end
endmodule : converter_protect_and_aux_rail_ctrl_tb

//--- testbench/mcu_model.sv
// microcontroller side of the register port: single byte writes and reads
// assumes the block takes a strobe on the rising edge of clk_sys
`timescale 1ns/10ps
module mcu_model
(
    // clock
    input wire logic clk_sys,
    // register port towards the block
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrEn,
    output logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid
);
    // idle port from time zero
    initial
    begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end

    // one byte write; strobe stands for exactly one edge
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_sys);
        regAddr <= addr;
        regWrData <= data;
        regWrEn <= 1'b1;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
        // released lines show the inverse so a stale value cannot pass
        regAddr <= ~addr;
        regWrData <= ~data;
    endtask : write_reg

    // one byte read; answer sampled in the cycle after the taking edge
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic vld);
        @(posedge clk_sys);
        regAddr <= addr;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        regAddr <= ~addr;
        @(negedge clk_sys);
        data = regRdData;
        vld = regRdValid;
    endtask : read_reg
endmodule : mcu_model
